// ### core/gate_ctrl_defines.vh
// constants for the three-phase gate control block
`ifndef GATE_CTRL_DEFINES_VH
`define GATE_CTRL_DEFINES_VH

// register byte offsets
`define OFS_CONFIG_FIRST      8'h00
`define OFS_CONFIG_THIRD      8'h08
`define OFS_STATUS            8'h10

// config_reg_first fields
`define F_SHORT_THR_LSB       0
`define F_SHORT_THR_MSB       1
`define F_SHORT_DET_EN        2
`define F_GATE_UV_EN          3
`define F_AMP_STBY_OFF        6
`define F_SLEEP_EN            7
`define RST_CONFIG_FIRST      8'h0C

// config_reg_third fields
`define F_DEAD_LSB            0
`define F_DEAD_MSB            2
`define F_BLANK_LSB           3
`define F_BLANK_MSB           4
`define RST_CONFIG_THIRD      8'h1F

// axi responses
`define RESP_OKAY             2'h0
`define RESP_SLVERR           2'h2

// short-circuit levels in millivolts, ascending by code
`define SHORT_MV_0            10'h0FA
`define SHORT_MV_1            10'h1F4
`define SHORT_MV_2            10'h2EE
`define SHORT_MV_3            10'h3E8

// timing, in nanoseconds
`define CLK_PERIOD_NS         5
`define DEAD_STEP_NS          250
`define BLANK_0_NS            500
`define BLANK_1_NS            1000
`define BLANK_2_NS            2000
`define BLANK_3_NS            4000
`define OE_OFF_NS             1000000
`define GATE_UV_QUAL_NS       10000

`endif

// ### core/sync2.v
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/1ps

module sync2 #(
   parameter WIDTH = 1
) (
   // clock and reset
   input  wire             aclk,
   input  wire             aresetn,
   // pin side and clock side
   input  wire [WIDTH-1:0] din,
   output reg  [WIDTH-1:0] dout
);

   reg [WIDTH-1:0] meta_q;

   // first stage feeds only the second
   always @(posedge aclk) begin
      if (!aresetn) begin
         meta_q <= {WIDTH{1'b0}};
         dout   <= {WIDTH{1'b0}};
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end

endmodule // sync2

// ### core/phase_channel.v
// one half-bridge: shoot-through block, dead time, blanking
`timescale 1ns/1ps

module phase_channel (
   // clock and reset
   input  wire        aclk,
   input  wire        aresetn,
   // drive requests, already synchronised
   input  wire        hi_in,
   input  wire        lo_in,
   input  wire        enable,
   // interval lengths in cycles
   input  wire [11:0] dead_cycles,
   input  wire [11:0] blank_cycles,
   // gate state
   output reg         hi_on,
   output reg         lo_on,
   output wire        blanking
);

   reg  [1:0]  tgt_q;
   reg  [11:0] dead_cnt_q;
   reg  [11:0] blank_cnt_q;
   wire [1:0]  tgt_d;

   // both requested means neither side on
   assign tgt_d    = {hi_in & ~lo_in & enable, lo_in & ~hi_in & enable};
   assign blanking = (blank_cnt_q != 12'h000);

   // any target change drops the gates first, then waits out the dead time
   always @(posedge aclk) begin
      if (!aresetn) begin
         tgt_q       <= 2'h0;
         hi_on       <= 1'b0;
         lo_on       <= 1'b0;
         dead_cnt_q  <= 12'h000;
         blank_cnt_q <= 12'h000;
      end else begin
         if (tgt_d != tgt_q) begin
            tgt_q      <= tgt_d;
            hi_on      <= 1'b0;
            lo_on      <= 1'b0;
            dead_cnt_q <= dead_cycles;
         end else if (dead_cnt_q != 12'h000) begin
            dead_cnt_q <= dead_cnt_q - 12'h001;
         end else if (tgt_q != 2'h0 && !hi_on && !lo_on) begin
            hi_on       <= tgt_q[1];
            lo_on       <= tgt_q[0];
            blank_cnt_q <= blank_cycles;
         end
         // blanking only runs once the gate is on
         if (blank_cnt_q != 12'h000 && (hi_on || lo_on) && tgt_d == tgt_q)
            blank_cnt_q <= blank_cnt_q - 12'h001;
         else if (tgt_d != tgt_q)
            blank_cnt_q <= 12'h000;
      end
   end

endmodule // phase_channel

// ### core/three_phase_gate_control.v
// top of the three-phase gate control block with its register slave
`timescale 1ns/1ps
`include "gate_ctrl_defines.vh"

module three_phase_gate_control #(
   parameter ADDR_W        = 8,
   parameter OE_OFF_CYCLES = (`OE_OFF_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
   parameter UV_QUAL_CYC   = (`GATE_UV_QUAL_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
   // clock and reset
   input  wire              aclk,
   input  wire              aresetn,
   // axi4-lite write address
   input  wire [ADDR_W-1:0] s_axi_awaddr,
   input  wire              s_axi_awvalid,
   output reg               s_axi_awready,
   // axi4-lite write data
   input  wire [31:0]       s_axi_wdata,
   input  wire [3:0]        s_axi_wstrb,
   input  wire              s_axi_wvalid,
   output reg               s_axi_wready,
   // axi4-lite write response
   output reg  [1:0]        s_axi_bresp,
   output reg               s_axi_bvalid,
   input  wire              s_axi_bready,
   // axi4-lite read
   input  wire [ADDR_W-1:0] s_axi_araddr,
   input  wire              s_axi_arvalid,
   output reg               s_axi_arready,
   output reg  [31:0]       s_axi_rdata,
   output reg  [1:0]        s_axi_rresp,
   output reg               s_axi_rvalid,
   input  wire              s_axi_rready,
   // host drive pins, phases a..c
   input  wire [2:0]        drive_hi_in,
   input  wire [2:0]        drive_lo_in,
   input  wire              output_enable,
   // analog comparator flags, high [2:0] then low [5:3]
   input  wire [5:0]        vds_over,
   input  wire [5:0]        gate_uv,
   // gate outputs
   output reg  [2:0]        high_gate_out,
   output reg  [2:0]        low_gate_out,
   // open-drain fault pin
   output reg               fault_pin_out,
   output reg               fault_pin_oe,
   // status message request toward the single_wire_link
   output reg               status_msg_req,
   output reg  [7:0]        status_msg_code,
   // analog side controls
   output reg  [9:0]        short_threshold_mv,
   output reg               amp_enable,
   output reg               standby,
   output reg               asleep
);

   localparam [11:0] DEAD_STEP_CYC = (`DEAD_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [11:0] BLANK_0_CYC   = (`BLANK_0_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [11:0] BLANK_1_CYC   = (`BLANK_1_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [11:0] BLANK_2_CYC   = (`BLANK_2_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [11:0] BLANK_3_CYC   = (`BLANK_3_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
   localparam [31:0] OE_OFF_MAX    = OE_OFF_CYCLES;
   localparam [31:0] UV_QUAL_MAX   = UV_QUAL_CYC;

   // synchronised pins
   wire [2:0]  hi_s;
   wire [2:0]  lo_s;
   wire        oe_s;
   wire [5:0]  vds_s;
   wire [5:0]  uv_s;

   // configuration and state
   reg  [7:0]  config_reg_first_q;
   reg  [7:0]  config_reg_third_q;
   reg         oe_prev_q;
   reg  [31:0] oe_low_cnt_q;
   reg  [31:0] uv_cnt_q;
   reg         short_fault_q;
   reg         uv_fault_q;

   // register bus state
   reg  [ADDR_W-1:0] aw_addr_q;
   reg  [31:0]       w_data_q;
   reg  [3:0]        w_strb_q;
   reg               aw_held_q;
   reg               w_held_q;

   // channel results
   wire [2:0]  ch_hi;
   wire [2:0]  ch_lo;
   wire [2:0]  ch_blank;
   wire [11:0] dead_cycles;
   reg  [11:0] blank_cycles;
   wire [5:0]  on_mask;
   wire [5:0]  blank_mask;
   wire        short_trip;
   wire        uv_trip;
   wire        short_fault_d;
   wire        uv_fault_d;
   wire        oe_rise;
   wire        gate_allow;
   wire        standby_d;
   wire        wr_fire;
   wire [ADDR_W-3:0] wr_idx;
   wire [ADDR_W-3:0] rd_idx;
   reg  [31:0] rd_mux;
   reg         rd_hit;

   // fields
   wire [1:0]  short_threshold_sel = config_reg_first_q[`F_SHORT_THR_MSB:`F_SHORT_THR_LSB];
   wire        short_detect_en     = config_reg_first_q[`F_SHORT_DET_EN];
   wire        gate_uv_detect_en   = config_reg_first_q[`F_GATE_UV_EN];
   wire [2:0]  dead_time_sel       = config_reg_third_q[`F_DEAD_MSB:`F_DEAD_LSB];
   wire [1:0]  blank_time_sel      = config_reg_third_q[`F_BLANK_MSB:`F_BLANK_LSB];

   // pins cross in through two flops each
   sync2 #(.WIDTH(19)) u_sync (
      .aclk    (aclk),
      .aresetn (aresetn),
      .din     ({drive_hi_in, drive_lo_in, output_enable, vds_over, gate_uv}),
      .dout    ({hi_s, lo_s, oe_s, vds_s, uv_s})
   );

   // interval lengths from the fields
   assign dead_cycles = {9'h000, dead_time_sel} * DEAD_STEP_CYC + DEAD_STEP_CYC;

   always @* begin
      case (blank_time_sel)
         2'h0:    blank_cycles = BLANK_0_CYC;
         2'h1:    blank_cycles = BLANK_1_CYC;
         2'h2:    blank_cycles = BLANK_2_CYC;
         default: blank_cycles = BLANK_3_CYC;
      endcase
   end

   // one channel per half-bridge
   genvar g;
   generate
      for (g = 0; g < 3; g = g + 1) begin : g_phase
         phase_channel u_ch (
            .aclk         (aclk),
            .aresetn      (aresetn),
            .hi_in        (hi_s[g]),
            .lo_in        (lo_s[g]),
            .enable       (gate_allow),
            .dead_cycles  (dead_cycles),
            .blank_cycles (blank_cycles),
            .hi_on        (ch_hi[g]),
            .lo_on        (ch_lo[g]),
            .blanking     (ch_blank[g])
         );
      end
   endgenerate

   // fault detection; comparator only counts while that gate is on
   assign on_mask       = {ch_lo, ch_hi};
   assign blank_mask    = {ch_blank, ch_blank};
   assign short_trip    = short_detect_en & |(vds_s & on_mask & ~blank_mask);
   assign uv_trip       = gate_uv_detect_en & (uv_cnt_q >= UV_QUAL_MAX);
   assign oe_rise       = oe_s & ~oe_prev_q;
   assign short_fault_d = short_trip | (short_fault_q & ~oe_rise);
   assign uv_fault_d    = uv_trip | (uv_fault_q & ~oe_rise);
   assign standby_d     = ~oe_s & (oe_low_cnt_q >= OE_OFF_MAX);
   assign gate_allow    = oe_s & ~short_fault_d & ~uv_fault_d & ~asleep;

   // fault latches; a trip in the clearing cycle wins
   always @(posedge aclk) begin
      if (!aresetn) begin
         short_fault_q <= 1'b0;
         uv_fault_q    <= 1'b0;
         oe_prev_q     <= 1'b0;
      end else begin
         short_fault_q <= short_fault_d;
         uv_fault_q    <= uv_fault_d;
         oe_prev_q     <= oe_s;
      end
   end

   // undervoltage qualification; counter pauses while blanking runs
   always @(posedge aclk) begin
      if (!aresetn) begin
         uv_cnt_q <= 32'h00000000;
      end else if (!gate_uv_detect_en || !(|(uv_s & on_mask))) begin
         uv_cnt_q <= 32'h00000000;
      end else if (!(|ch_blank) && uv_cnt_q < UV_QUAL_MAX) begin
         uv_cnt_q <= uv_cnt_q + 32'h00000001;
      end
   end

   // output-enable low timer for standby and sleep
   always @(posedge aclk) begin
      if (!aresetn) begin
         oe_low_cnt_q <= 32'h00000000;
      end else if (oe_s) begin
         oe_low_cnt_q <= 32'h00000000;
      end else if (oe_low_cnt_q < OE_OFF_MAX) begin
         oe_low_cnt_q <= oe_low_cnt_q + 32'h00000001;
      end
   end

   // gate pins; gated again here so a trip cuts them in one cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         high_gate_out <= 3'h0;
         low_gate_out  <= 3'h0;
      end else begin
         high_gate_out <= ch_hi & {3{gate_allow}};
         low_gate_out  <= ch_lo & {3{gate_allow}};
      end
   end

   // fault pin and status message on each new fault
   always @(posedge aclk) begin
      if (!aresetn) begin
         fault_pin_out   <= 1'b0;
         fault_pin_oe    <= 1'b0;
         status_msg_req  <= 1'b0;
         status_msg_code <= 8'h00;
      end else begin
         fault_pin_out  <= 1'b0;
         fault_pin_oe   <= short_fault_d | uv_fault_d;
         status_msg_req <= (short_fault_d & ~short_fault_q) | (uv_fault_d & ~uv_fault_q);
         if ((short_fault_d & ~short_fault_q) | (uv_fault_d & ~uv_fault_q))
            status_msg_code <= {6'h00, uv_fault_d, short_fault_d};
      end
   end

   // power modes and analog controls
   always @(posedge aclk) begin
      if (!aresetn) begin
         standby            <= 1'b0;
         asleep             <= 1'b0;
         amp_enable         <= 1'b0;
         short_threshold_mv <= `SHORT_MV_0;
      end else begin
         standby    <= standby_d & ~config_reg_first_q[`F_SLEEP_EN];
         asleep     <= standby_d & config_reg_first_q[`F_SLEEP_EN];
         amp_enable <= ~(standby_d & config_reg_first_q[`F_SLEEP_EN]) &
                       ~(standby_d & config_reg_first_q[`F_AMP_STBY_OFF]);
         case (short_threshold_sel)
            2'h0:    short_threshold_mv <= `SHORT_MV_0;
            2'h1:    short_threshold_mv <= `SHORT_MV_1;
            2'h2:    short_threshold_mv <= `SHORT_MV_2;
            default: short_threshold_mv <= `SHORT_MV_3;
         endcase
      end
   end

   // write channel: address and data taken in either order
   assign wr_fire = aw_held_q & w_held_q & ~s_axi_bvalid;
   assign wr_idx  = aw_addr_q[ADDR_W-1:2];

   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `RESP_OKAY;
         aw_held_q     <= 1'b0;
         w_held_q      <= 1'b0;
         aw_addr_q     <= {ADDR_W{1'b0}};
         w_data_q      <= 32'h00000000;
         w_strb_q      <= 4'h0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_addr_q     <= s_axi_awaddr;
            aw_held_q     <= 1'b1;
            s_axi_awready <= 1'b0;
         end else if (!aw_held_q && !s_axi_bvalid) begin
            s_axi_awready <= 1'b1;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_data_q     <= s_axi_wdata;
            w_strb_q     <= s_axi_wstrb;
            w_held_q     <= 1'b1;
            s_axi_wready <= 1'b0;
         end else if (!w_held_q && !s_axi_bvalid) begin
            s_axi_wready <= 1'b1;
         end
         if (wr_fire) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_idx == `OFS_CONFIG_FIRST >> 2 ||
                             wr_idx == `OFS_CONFIG_THIRD >> 2) ? `RESP_OKAY : `RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // configuration registers; only byte lane 0 holds fields
   always @(posedge aclk) begin
      if (!aresetn) begin
         config_reg_first_q <= `RST_CONFIG_FIRST;
         config_reg_third_q <= `RST_CONFIG_THIRD;
      end else if (wr_fire && w_strb_q[0]) begin
         if (wr_idx == `OFS_CONFIG_FIRST >> 2)
            config_reg_first_q <= w_data_q[7:0] & 8'hCF;
         if (wr_idx == `OFS_CONFIG_THIRD >> 2)
            config_reg_third_q <= w_data_q[7:0] & 8'h1F;
      end
   end

   // read mux; status shows live block state
   assign rd_idx = s_axi_araddr[ADDR_W-1:2];

   always @* begin
      rd_mux = 32'h00000000;
      rd_hit = 1'b1;
      case (rd_idx)
         `OFS_CONFIG_FIRST >> 2: rd_mux = {24'h000000, config_reg_first_q};
         `OFS_CONFIG_THIRD >> 2: rd_mux = {24'h000000, config_reg_third_q};
         `OFS_STATUS >> 2:       rd_mux = {21'h000000, low_gate_out, high_gate_out, asleep,
                                           standby, oe_s, uv_fault_q, short_fault_q};
         default:                rd_hit = 1'b0;
      endcase
   end

   // read channel: answer one cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= `RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_mux;
         s_axi_rresp   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

endmodule // three_phase_gate_control

// ### verif/three_phase_gate_control_assertions.sv
// concurrent checks on the gate control ports
`timescale 1ns/1ps

module three_phase_gate_control_assertions (
   // clock and reset
   input wire       aclk,
   input wire       aresetn,
   // host side
   input wire [2:0] drive_hi_in,
   input wire [2:0] drive_lo_in,
   input wire       output_enable,
   input wire       s_axi_bvalid,
   input wire       s_axi_bready,
   // gate and status side
   input wire [2:0] high_gate_out,
   input wire [2:0] low_gate_out,
   input wire       fault_pin_out,
   input wire       fault_pin_oe,
   input wire       status_msg_req,
   input wire [9:0] short_threshold_mv,
   input wire       amp_enable,
   input wire       asleep
);
   reg [1:0]  prev_q;
   reg [11:0] stab_q;

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // cycles since phase a requests last moved, saturating
   always @(posedge aclk) begin
      prev_q <= {drive_hi_in[0], drive_lo_in[0]};
      if (!aresetn || prev_q != {drive_hi_in[0], drive_lo_in[0]}) begin
         stab_q <= 12'h000;
      end else if (stab_q != 12'hFFF) begin
         stab_q <= stab_q + 12'h001;
      end
   end

   a_no_shoot: assert property ((high_gate_out & low_gate_out) == 3'h0)
      else $error("both gates of one phase on");
   a_cross_off: assert property ((drive_hi_in[0] && drive_lo_in[0]) [*6]
      |-> !high_gate_out[0] && !low_gate_out[0]) else $error("cross request not blocked");
   a_oe_off: assert property (!output_enable [*6] |-> {high_gate_out, low_gate_out} == 6'h00)
      else $error("gates on with output enable low");
   a_dead_min: assert property (($rose(high_gate_out[0]) || $rose(low_gate_out[0]))
      |-> stab_q >= 12'h032) else $error("gate on before dead time");
   a_fault_off: assert property (fault_pin_oe |-> {high_gate_out, low_gate_out} == 6'h00)
      else $error("gates on during fault");
   a_fault_hold: assert property ((fault_pin_oe && output_enable) [*6] |=> fault_pin_oe)
      else $error("fault cleared without enable edge");
   a_fault_msg: assert property ($rose(fault_pin_oe) |-> status_msg_req)
      else $error("no status message on fault");
   a_msg_pulse: assert property (status_msg_req |=> !status_msg_req)
      else $error("status request longer than one cycle");
   a_pin_low: assert property (fault_pin_out == 1'b0)
      else $error("open-drain fault pin driven high");
   a_thr_level: assert property (short_threshold_mv inside {10'h0FA, 10'h1F4, 10'h2EE, 10'h3E8})
      else $error("threshold level not one of four");
   a_amp_sleep: assert property (asleep |-> !amp_enable)
      else $error("amplifiers on while asleep");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped early");
endmodule // three_phase_gate_control_assertions

// ### verif/host_phase_model.sv
// host model driving the phase request pins from a mode code
`timescale 1ns/1ps

module host_phase_model (
   // clock
   input  wire       aclk,
   // mode: 1 bootstrap, 2 lock, 3..8 states 1..6, 9 cross request
   input  wire [3:0] mode,
   // phase request pins
   output reg  [2:0] drive_hi_in,
   output reg  [2:0] drive_lo_in
);
   initial begin
      drive_hi_in = 3'h0;
      drive_lo_in = 3'h0;
   end

   // pins move just after the edge like a port register
   always @(posedge aclk) begin
      case (mode)
         4'h1: {drive_hi_in, drive_lo_in} <= 6'h07;
         4'h2: {drive_hi_in, drive_lo_in} <= 6'h2A;
         4'h3: {drive_hi_in, drive_lo_in} <= 6'h0C;
         4'h4: {drive_hi_in, drive_lo_in} <= 6'h14;
         4'h5: {drive_hi_in, drive_lo_in} <= 6'h11;
         4'h6: {drive_hi_in, drive_lo_in} <= 6'h21;
         4'h7: {drive_hi_in, drive_lo_in} <= 6'h22;
         4'h8: {drive_hi_in, drive_lo_in} <= 6'h0A;
         4'h9: {drive_hi_in, drive_lo_in} <= 6'h09;
         default: {drive_hi_in, drive_lo_in} <= 6'h00;
      endcase
   end
endmodule // host_phase_model

// ### verif/three_phase_gate_control_tb.sv
// self-checking bench for the three-phase gate control block
`timescale 1ns/1ps

module three_phase_gate_control_tb;
   reg         aclk, aresetn, output_enable;
   reg  [7:0]  s_axi_awaddr, s_axi_araddr;
   reg  [31:0] s_axi_wdata;
   reg  [3:0]  s_axi_wstrb, mode;
   reg         s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   reg  [5:0]  vds_over, gate_uv;
   wire        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [2:0]  drive_hi_in, drive_lo_in, high_gate_out, low_gate_out;
   wire        fault_pin_out, fault_pin_oe, status_msg_req, amp_enable, standby, asleep;
   wire [7:0]  status_msg_code;
   wire [9:0]  short_threshold_mv;
   integer     fail_count, num_checks, i, d;

   // short standby and undervoltage counts keep the run brief
   three_phase_gate_control #(.OE_OFF_CYCLES(20), .UV_QUAL_CYC(8)) u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .drive_hi_in, .drive_lo_in,
      .output_enable, .vds_over, .gate_uv, .high_gate_out, .low_gate_out,
      .fault_pin_out, .fault_pin_oe, .status_msg_req, .status_msg_code,
      .short_threshold_mv, .amp_enable, .standby, .asleep);
   host_phase_model u_host (.aclk, .mode, .drive_hi_in, .drive_lo_in);

   // 200 MHz clock
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end

   task check(input string what, input [31:0] seen, input [31:0] exp);
      begin
         num_checks = num_checks + 1;
         if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("Error %s expected %h seen %h", what, exp, seen);
         end
      end
   endtask

   task results;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0) begin
            $display("Testbench passed");
         end else begin
            $display("Testbench failed");
         end
         $finish;
      end
   endtask

   // a handshake that never comes ends the run
   task give_up;
      begin
         check("handshake", 0, 1);
         results;
      end
   endtask

   task axi_write(input [7:0] a, input [31:0] v, input [1:0] er);
      integer n;
      begin
         @(posedge aclk);
         s_axi_awaddr <= a;
         s_axi_wdata <= v;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            // late bready makes the response wait a cycle
            if (n == 3) s_axi_bready <= 1'b1;
            if (n > 50) give_up;
         end while (s_axi_bvalid !== 1'b1 || s_axi_bready !== 1'b1);
         check("bresp", s_axi_bresp, er);
         s_axi_bready <= 1'b0;
      end
   endtask

   task axi_read(input [7:0] a, input [31:0] ev, input [1:0] er);
      integer n;
      begin
         @(posedge aclk);
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
         n = 0;
         do begin
            @(posedge aclk);
            n = n + 1;
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (n > 50) give_up;
         end while (s_axi_rvalid !== 1'b1);
         check("rresp", s_axi_rresp, er);
         if (er == 2'h0) check("rdata", s_axi_rdata, ev);
         s_axi_rready <= 1'b0;
      end
   endtask

   // reset values, reserved bits, unmapped places
   task t_regs;
      begin
         axi_read(8'h00, 32'h0000000C, 2'h0);
         axi_read(8'h08, 32'h0000001F, 2'h0);
         axi_read(8'h10, 32'h00000004, 2'h0);
         axi_read(8'h04, 32'h00000000, 2'h2);
         axi_write(8'h20, 32'h00000000, 2'h2);
         axi_write(8'h08, 32'h000000FF, 2'h0);
         axi_read(8'h08, 32'h0000001F, 2'h0);
         $display("test regs done");
      end
   endtask

   // every dead-time code: off before the count, on after it
   task t_dead;
      begin
         for (i = 0; i < 8; i = i + 1) begin
            axi_write(8'h08, i, 2'h0);
            mode <= 4'h0;
            repeat (20) @(posedge aclk);
            mode <= 4'h3;
            d = (i + 1) * 50;
            repeat (d) @(posedge aclk);
            check("gate early", {high_gate_out, low_gate_out}, 6'h00);
            repeat (15) @(posedge aclk);
            check("gate late", {high_gate_out, low_gate_out}, 6'h0C);
         end
         $display("test dead done");
      end
   endtask

   // bootstrap, lock, then six steps ramping up and six in reverse
   task t_comm;
      begin
         axi_write(8'h08, 32'h00000000, 2'h0);
         for (i = 0; i < 14; i = i + 1) begin
            mode <= (i < 8) ? i + 1 : 16 - i;
            repeat (140 - 5 * i) @(posedge aclk);
            check("step", {high_gate_out, low_gate_out}, {drive_hi_in, drive_lo_in});
         end
         mode <= 4'h9;
         repeat (40) @(posedge aclk);
         check("cross", {high_gate_out, low_gate_out}, 6'h00);
         $display("test comm done");
      end
   endtask

   // all four threshold codes
   task t_thr;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            axi_write(8'h00, 32'h0000000C | i, 2'h0);
            repeat (3) @(posedge aclk);
            check("threshold", short_threshold_mv, (i + 1) * 250);
         end
         axi_write(8'h00, 32'h0000000C, 2'h0);
         $display("test thr done");
      end
   endtask

   // comparator pulse after w cycles for p cycles, then enable toggle
   task trip(input integer w, input integer p, input [5:0] v, input [5:0] u, input e);
      begin
         repeat (w) @(posedge aclk);
         vds_over <= v;
         gate_uv <= u;
         repeat (p) @(posedge aclk);
         vds_over <= 6'h00;
         gate_uv <= 6'h00;
         repeat (5) @(posedge aclk);
         check("fault", fault_pin_oe, e);
         if (e) check("msg code", status_msg_code[1:0], {u[0], v[0]});
         output_enable <= 1'b0;
         repeat (3) @(posedge aclk);
         output_enable <= 1'b1;
         repeat (6) @(posedge aclk);
         check("cleared", fault_pin_oe, 1'b0);
      end
   endtask

   task t_fault;
      begin
         mode <= 4'h3;
         trip(200, 3, 6'h01, 6'h00, 1'b1);
         trip(90, 3, 6'h01, 6'h00, 1'b0);
         trip(200, 3, 6'h02, 6'h00, 1'b0);
         trip(200, 20, 6'h00, 6'h01, 1'b1);
         axi_write(8'h00, 32'h00000008, 2'h0);
         trip(200, 3, 6'h01, 6'h00, 1'b0);
         axi_write(8'h00, 32'h0000000C, 2'h0);
         $display("test fault done");
      end
   endtask

   // enable low: gates off at once, standby later, amplifier choice
   task t_oe;
      begin
         output_enable <= 1'b0;
         repeat (6) @(posedge aclk);
         check("oe gates", {high_gate_out, low_gate_out}, 6'h00);
         repeat (25) @(posedge aclk);
         check("standby", standby, 1'b1);
         check("amp on", amp_enable, 1'b1);
         axi_write(8'h00, 32'h0000004C, 2'h0);
         repeat (3) @(posedge aclk);
         check("amp off", amp_enable, 1'b0);
         axi_write(8'h00, 32'h000000CC, 2'h0);
         repeat (3) @(posedge aclk);
         check("asleep", asleep, 1'b1);
         output_enable <= 1'b1;
         $display("test oe done");
      end
   endtask

   // reset for two cycles, then the scenarios in turn
   initial begin
      {aresetn, s_axi_awaddr, s_axi_araddr, s_axi_wdata, mode} = 0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
      {vds_over, gate_uv} = 12'h000;
      s_axi_wstrb = 4'hF;
      output_enable = 1'b1;
      fail_count = 0;
      num_checks = 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_regs;
      t_dead;
      t_comm;
      t_thr;
      t_fault;
      t_oe;
      results;
   end
endmodule // three_phase_gate_control_tb

bind three_phase_gate_control three_phase_gate_control_assertions u_chk (
   .aclk, .aresetn, .drive_hi_in, .drive_lo_in, .output_enable, .s_axi_bvalid,
   .s_axi_bready, .high_gate_out, .low_gate_out, .fault_pin_out, .fault_pin_oe,
   .status_msg_req, .short_threshold_mv, .amp_enable, .asleep);
